/* File: design/otd_pkg.sv */
/*
 * Shared constants and types for the orientation and tap detector.
 * Assumes a single 125 MHz clock domain and an AHB-Lite register port.
 */
package otd_pkg;

  // ****************************************************************
  // Register map and fields.
  // ****************************************************************
  localparam logic [7:0] OTD_ADDR_CTRL    = 8'h00;
  localparam logic [7:0] OTD_ADDR_STATUS  = 8'h04;
  localparam logic [7:0] OTD_ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] OTD_ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0] OTD_ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] OTD_ADDR_DBL_WIN = 8'h14;

  localparam int OTD_CTRL_TAP_EN  = 0;
  localparam int OTD_CTRL_DBL_EN  = 1;
  localparam int OTD_IRQ_SINGLE   = 0;
  localparam int OTD_IRQ_DOUBLE   = 1;
  localparam int OTD_IRQ_ORIENT   = 2;
  localparam int OTD_IRQ_BITS     = 3;

  localparam logic [1:0]  OTD_CTRL_RST    = 2'h1;
  localparam logic [31:0] OTD_DBL_WIN_RST = 32'h0003_D090;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int OTD_CLK_MHZ     = 125;
  localparam int OTD_TURN_ON_MS  = 30;
  localparam int OTD_TURN_ON_CYC = OTD_TURN_ON_MS * 1000 * OTD_CLK_MHZ;
  localparam int OTD_STEADY_CYC  = 16;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    OTD_OR_NONE   = 3'h0,
    OTD_OR_PORT_U = 3'h1,
    OTD_OR_PORT_D = 3'h2,
    OTD_OR_LAND_L = 3'h3,
    OTD_OR_LAND_R = 3'h4,
    OTD_OR_FACE_U = 3'h5,
    OTD_OR_FACE_D = 3'h6
  } otd_orient_t;

  typedef struct packed {
    logic portrait;
    logic landscape;
    logic polarity;
  } otd_lines_t;

  typedef enum logic [1:0] {
    OTD_TS_IDLE = 2'h0,
    OTD_TS_WAIT = 2'h1
  } otd_tap_state_t;

endpackage

/* File: design/otd_tap_det.sv */
/*
 * Tap and double-tap classifier.
 * Assumes tap pulses are already synchronous one-cycle events.
 */
`timescale 1ns/100ps
`default_nettype none
module otd_tap_det
  import otd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        run_in,
  input  wire logic        dbl_en_in,
  input  wire logic [31:0] win_in,
  input  wire logic        tap_in,
  output logic             single_out,
  output logic             double_out
);

  otd_tap_state_t state_r, state_nxt;
  logic [31:0]    cnt_r, cnt_nxt;
  logic           single_nxt, double_nxt;

  // A tap with double enabled waits for a second within the window.
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    single_nxt = 1'b0;
    double_nxt = 1'b0;
    if (!run_in) begin
      state_nxt = OTD_TS_IDLE;
      cnt_nxt   = 32'h0;
    end else begin
      case (state_r)
        OTD_TS_IDLE: begin
          if (tap_in) begin
            if (dbl_en_in) begin
              state_nxt = OTD_TS_WAIT;
              cnt_nxt   = 32'h0;
            end else begin
              single_nxt = 1'b1;
            end
          end
        end
        OTD_TS_WAIT: begin
          if (tap_in) begin
            double_nxt = 1'b1; // see RULE_10
            state_nxt  = OTD_TS_IDLE;
          end else if (cnt_r >= win_in) begin
            single_nxt = 1'b1;
            state_nxt  = OTD_TS_IDLE;
          end else begin
            cnt_nxt = cnt_r + 32'h1;
          end
        end
        default: state_nxt = OTD_TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r    <= OTD_TS_IDLE;
      cnt_r      <= 32'h0;
      single_out <= 1'b0;
      double_out <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      single_out <= single_nxt;
      double_out <= double_nxt;
    end
  end

  a_double_window: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_10
    double_out |-> $past(state_r) == OTD_TS_WAIT && $past(tap_in))
    else $error("double tap reported outside its window");

endmodule
`default_nettype wire

/* File: design/otd_top.sv */
/*
 * Orientation and tap detector: orientation lines, tap interrupt,
 * sleep handling and AHB-Lite registers.
 * Assumes sensed axis signs and tap pulses come from pins (async) and
 * one AHB-Lite master on the same clock.
 */
// Behaviour
// (RULE_01) Steady position is classified into one of six orientations on output lines.
// (RULE_02) portrait_flag is high exactly while a portrait orientation is detected.
// (RULE_03) landscape_flag is high exactly while a landscape orientation is detected.
// (RULE_04) direction_polarity tells apart the two senses of each orientation.
// (RULE_05) Face orientation keeps both flags low; polarity alone gives up or down.
// (RULE_06) The device follows sleep_n: low means sleep, high means normal.
// (RULE_07) While sleep_n is low the measurement chain stays off.
// (RULE_08) Outputs become valid 30 ms after sleep_n returns high.
// (RULE_09) When enabled, any tap raises the interrupt line.
// (RULE_10) Optional double tap: second tap must come within a programmable window.
`timescale 1ns/100ps
`default_nettype none
module otd_top
  import otd_pkg::*;
#(
  parameter int TURN_ON_CYC = OTD_TURN_ON_CYC,
  parameter int STEADY_CYC  = OTD_STEADY_CYC
)(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        sleep_n_in,
  input  wire logic [2:0]  axis_hit_in,
  input  wire logic        axis_neg_in,
  input  wire logic        tap_in,
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             portrait_flag_out,
  output logic             landscape_flag_out,
  output logic             direction_polarity_out,
  output logic             valid_out,
  output logic             irq_out
);

  // ****************************************************************
  // Parameter checks.
  // ****************************************************************
  if (TURN_ON_CYC < 1 || STEADY_CYC < 1 || STEADY_CYC > 65535) begin : g_bad_counts
    $error("otd_top: counts must lie between one and the counter limits");
  end

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  // Every tap, sleep and axis pin is a level from outside and passes two flops before use; the AHB-Lite pins are not synchronised.
  logic [5:0] sync1_r, sync2_r;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_r <= 6'h0;
      sync2_r <= 6'h0;
    end else begin
      sync1_r <= {tap_in, sleep_n_in, axis_neg_in, axis_hit_in};
      sync2_r <= sync1_r;
    end
  end
  logic [2:0] hit_s;
  logic       neg_s, awake_s, tap_s, tap_d_r;
  assign hit_s   = sync2_r[2:0];
  assign neg_s   = sync2_r[3];
  assign awake_s = sync2_r[4];
  assign tap_s   = sync2_r[5];

  // ****************************************************************
  // Wake timer and measurement chain enable.
  // ****************************************************************
  logic [31:0] wake_cnt_r, wake_cnt_nxt;
  logic        run_r, run_nxt, valid_nxt;
  always_comb begin
    wake_cnt_nxt = wake_cnt_r;
    run_nxt      = awake_s; // see RULE_06
    valid_nxt    = 1'b0;
    if (!awake_s) begin
      wake_cnt_nxt = 32'h0; // see RULE_07
    end else if (wake_cnt_r < 32'(TURN_ON_CYC)) begin
      wake_cnt_nxt = wake_cnt_r + 32'h1;
    end else begin
      valid_nxt = 1'b1; // see RULE_08
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_cnt_r <= 32'h0;
      run_r      <= 1'b0;
      valid_out  <= 1'b0;
    end else begin
      wake_cnt_r <= wake_cnt_nxt;
      run_r      <= run_nxt;
      valid_out  <= valid_nxt;
    end
  end

  // ****************************************************************
  // Orientation classifier with steadiness filter.
  // ****************************************************************
  otd_orient_t cand, cand_r, cur_r, cur_nxt;
  logic [15:0] stdy_r, stdy_nxt;
  otd_lines_t  lines;
  always_comb begin
    case ({hit_s, neg_s})
      4'h2:    cand = OTD_OR_PORT_U;
      4'h3:    cand = OTD_OR_PORT_D;
      4'h4:    cand = OTD_OR_LAND_L;
      4'h5:    cand = OTD_OR_LAND_R;
      4'h8:    cand = OTD_OR_FACE_U;
      4'h9:    cand = OTD_OR_FACE_D;
      default: cand = OTD_OR_NONE;
    endcase
  end
  always_comb begin
    cur_nxt  = cur_r;
    stdy_nxt = stdy_r;
    if (!run_r) begin
      cur_nxt  = OTD_OR_NONE; // see RULE_07
      stdy_nxt = 16'h0;
    end else if (cand != cand_r) begin
      stdy_nxt = 16'h0;
    end else if (stdy_r < 16'(STEADY_CYC)) begin
      stdy_nxt = stdy_r + 16'h1;
    end else if (valid_nxt && cand != OTD_OR_NONE) begin
      cur_nxt = cand; // see RULE_01
    end
  end
  always_comb begin
    lines.portrait  = (cur_nxt == OTD_OR_PORT_U) || (cur_nxt == OTD_OR_PORT_D); // see RULE_02
    lines.landscape = (cur_nxt == OTD_OR_LAND_L) || (cur_nxt == OTD_OR_LAND_R); // see RULE_03
    // Face keeps both flags low and only the polarity differs. See RULE_05.
    lines.polarity  = (cur_nxt == OTD_OR_PORT_D) || (cur_nxt == OTD_OR_LAND_R)
                   || (cur_nxt == OTD_OR_FACE_D); // see RULE_04
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cand_r                 <= OTD_OR_NONE;
      cur_r                  <= OTD_OR_NONE;
      stdy_r                 <= 16'h0;
      tap_d_r                <= 1'b0;
      portrait_flag_out      <= 1'b0;
      landscape_flag_out     <= 1'b0;
      direction_polarity_out <= 1'b0;
    end else begin
      cand_r                 <= cand;
      cur_r                  <= cur_nxt;
      stdy_r                 <= stdy_nxt;
      tap_d_r                <= tap_s;
      portrait_flag_out      <= lines.portrait;
      landscape_flag_out     <= lines.landscape;
      direction_polarity_out <= lines.polarity;
    end
  end

  // ****************************************************************
  // Tap detection.
  // ****************************************************************
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic [31:0] win_r, win_nxt;
  logic        single_ev, double_ev;
  otd_tap_det u_tap (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .run_in     (valid_out && ctrl_r[OTD_CTRL_TAP_EN]),
    .dbl_en_in  (ctrl_r[OTD_CTRL_DBL_EN]),
    .win_in     (win_r),
    .tap_in     (tap_s && !tap_d_r),
    .single_out (single_ev),
    .double_out (double_ev)
  );

  // ****************************************************************
  // AHB-Lite slave and interrupt registers.
  // ****************************************************************
  logic [OTD_IRQ_BITS-1:0] ist_r, ist_nxt, ien_r, ien_nxt, ev;
  logic        ph_wr_r, ph_rd_r, ph_wr_nxt, ph_rd_nxt, irq_nxt;
  logic [7:0]  ph_addr_r, ph_addr_nxt;
  logic [31:0] rdata_nxt;
  logic        orient_chg;
  logic        word_acc;
  // Only whole-word transfers reach the registers; other sizes are ignored.
  assign word_acc   = (hsize_in == 3'h2);
  assign orient_chg = run_r && (cur_nxt != cur_r);
  assign ev = {orient_chg, double_ev, single_ev};

  always_comb begin
    ph_wr_nxt   = hsel_in && hready_in && htrans_in[1] && hwrite_in && word_acc;
    ph_rd_nxt   = hsel_in && hready_in && htrans_in[1] && !hwrite_in && word_acc;
    ph_addr_nxt = hready_in ? haddr_in : ph_addr_r;
    ctrl_nxt    = ctrl_r;
    win_nxt     = win_r;
    ien_nxt     = ien_r;
    ist_nxt     = ist_r;
    rdata_nxt   = 32'h0;
    if (ph_wr_r) begin
      case (ph_addr_r)
        OTD_ADDR_CTRL:    ctrl_nxt = hwdata_in[1:0];
        OTD_ADDR_IRQ_EN:  ien_nxt  = hwdata_in[OTD_IRQ_BITS-1:0];
        OTD_ADDR_IRQ_CLR: ist_nxt  = ist_r & ~hwdata_in[OTD_IRQ_BITS-1:0];
        OTD_ADDR_DBL_WIN: win_nxt  = hwdata_in; // see RULE_10
        default: ;
      endcase
    end
    // A new event wins over a clear written in the same cycle.
    ist_nxt = ist_nxt | ev; // see RULE_09
    // Read data is registered in the address phase and stands for the data phase.
    if (ph_rd_nxt) begin
      case (haddr_in)
        OTD_ADDR_CTRL:    rdata_nxt = {30'h0, ctrl_r};
        OTD_ADDR_STATUS:  rdata_nxt = {25'h0, valid_out, run_r, 2'h0, cur_r};
        OTD_ADDR_IRQ_ST:  rdata_nxt = {29'h0, ist_r};
        OTD_ADDR_IRQ_EN:  rdata_nxt = {29'h0, ien_r};
        OTD_ADDR_DBL_WIN: rdata_nxt = win_r;
        default:          rdata_nxt = 32'h0;
      endcase
    end
    irq_nxt = |(ist_nxt & ien_nxt); // see RULE_09
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ph_wr_r       <= 1'b0;
      ph_rd_r       <= 1'b0;
      ph_addr_r     <= 8'h0;
      ctrl_r        <= OTD_CTRL_RST;
      win_r         <= OTD_DBL_WIN_RST;
      ien_r         <= 3'h0;
      ist_r         <= 3'h0;
      hrdata_out    <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      irq_out       <= 1'b0;
    end else begin
      ph_wr_r       <= ph_wr_nxt;
      ph_rd_r       <= ph_rd_nxt;
      ph_addr_r     <= ph_addr_nxt;
      ctrl_r        <= ctrl_nxt;
      win_r         <= win_nxt;
      ien_r         <= ien_nxt;
      ist_r         <= ist_nxt;
      hrdata_out    <= rdata_nxt;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      irq_out       <= irq_nxt;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_flags_exclusive: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_01
    !(portrait_flag_out && landscape_flag_out))
    else $error("both orientation flags high");
  a_portrait_flag: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_02
    portrait_flag_out == (cur_r == OTD_OR_PORT_U || cur_r == OTD_OR_PORT_D))
    else $error("portrait flag disagrees with orientation");
  a_landscape_flag: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_03
    landscape_flag_out == (cur_r == OTD_OR_LAND_L || cur_r == OTD_OR_LAND_R))
    else $error("landscape flag disagrees with orientation");
  a_polarity_line: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_04
    direction_polarity_out == (cur_r inside {OTD_OR_PORT_D, OTD_OR_LAND_R, OTD_OR_FACE_D}))
    else $error("polarity line disagrees with orientation");
  a_face_flags: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_05
    (cur_r == OTD_OR_FACE_U || cur_r == OTD_OR_FACE_D)
      |-> !portrait_flag_out && !landscape_flag_out)
    else $error("face orientation raised a flag");
  a_orient_event: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_01
    (run_r && cur_nxt != cur_r) |=> ist_r[OTD_IRQ_ORIENT])
    else $error("orientation change left no status bit");
  a_sleep_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_06
    !awake_s |=> !run_r)
    else $error("chain not stopped after sleep");
  a_sleep_chain_off: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_07
    !run_r |=> cur_r == OTD_OR_NONE && !single_ev && !double_ev)
    else $error("chain active while asleep");
  a_asleep_flags: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_07
    !run_r |=> !portrait_flag_out && !landscape_flag_out && !direction_polarity_out)
    else $error("orientation lines high while asleep");
  a_wake_valid: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_08
    valid_out |-> wake_cnt_r == 32'(TURN_ON_CYC))
    else $error("valid before turn-on time");
  a_valid_run: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_08
    valid_out |-> run_r)
    else $error("valid reported while the chain is off");
  a_tap_irq: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_09
    (single_ev && ien_r[OTD_IRQ_SINGLE] && !(ph_wr_r && ph_addr_r == OTD_ADDR_IRQ_EN))
      |=> irq_out && ist_r[OTD_IRQ_SINGLE])
    else $error("tap did not raise interrupt");
  a_irq_level: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see RULE_09
    irq_out == |(ist_r & ien_r))
    else $error("interrupt line disagrees with enabled status");
  a_rdata_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !ph_rd_r |-> hrdata_out == 32'h0)
    else $error("read data driven outside a read data phase");

endmodule
`default_nettype wire

/* File: verification/otd_host_model.sv */
/*
 * Host model: drives the sleep line and latches the orientation lines.
 * Assumes the detector's registered outputs share its clock.
 */
`timescale 1ns/100ps
`default_nettype none
module otd_host_model
  import otd_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       wake_in,
  input  wire otd_lines_t lines_in,
  input  wire logic       valid_in,
  output logic            sleep_n_out,
  output otd_lines_t      seen_out
);
  // ****************************************************************
  // Sleep control and line sampling.
  // ****************************************************************
  // Lines are only trusted once the detector reports valid data.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sleep_n_out <= 1'b0;
      seen_out    <= '0;
    end else begin
      sleep_n_out <= wake_in;
      if (valid_in) begin
        seen_out <= lines_in;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_orientation_tap_detector.sv */
/*
 * Self-checking bench for the orientation and tap detector.
 * Assumes the host model on the sleep line and AHB-Lite single word cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_orientation_tap_detector;
  import otd_pkg::*;
  // ****************************************************************
  // Signals and instances.
  // ****************************************************************
  localparam int TON = 50;
  localparam int WIN = 40;
  logic        clk_in, arst_n_in, wake, tap, hsel, hwrite, hready, hresp;
  logic        pf, lf, dp, valid, irq, sleep_n;
  logic [3:0]  axis;
  logic [2:0]  hsize;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, q;
  otd_lines_t  seen;
  integer      seed, error_cnt, check_count, n, g;
  logic [5:0]  e;
  logic [3:0]  tbl [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};

  otd_top #(.TURN_ON_CYC(TON), .STEADY_CYC(4)) i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .sleep_n_in(sleep_n),
    .axis_hit_in(axis[3:1]), .axis_neg_in(axis[0]), .tap_in(tap),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .portrait_flag_out(pf),
    .landscape_flag_out(lf), .direction_polarity_out(dp), .valid_out(valid),
    .irq_out(irq)
  );
  otd_host_model i_host (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .wake_in(wake),
    .lines_in({pf, lf, dp}), .valid_in(valid), .sleep_n_out(sleep_n), .seen_out(seen)
  );

  // ****************************************************************
  // Tasks and expectation functions.
  // ****************************************************************
  task automatic results;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt_rdy;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      results();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
    wt_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wt_rdy();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic tp;
    tap <= 1'b1;
    repeat (3) @(posedge clk_in);
    tap <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic wt_valid;
    n = 0;
    while (valid !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      results();
    end
  endtask

  // Returns the status code and the {portrait, landscape, polarity} lines.
  function automatic logic [5:0] exp_or(input logic [3:0] c);
    case (c)
      4'h2: exp_or = {OTD_OR_PORT_U, 3'b100};
      4'h3: exp_or = {OTD_OR_PORT_D, 3'b101};
      4'h4: exp_or = {OTD_OR_LAND_L, 3'b010};
      4'h5: exp_or = {OTD_OR_LAND_R, 3'b011};
      4'h8: exp_or = {OTD_OR_FACE_U, 3'b000};
      default: exp_or = {OTD_OR_FACE_D, 3'b001};
    endcase
  endfunction

  task automatic chk_or;
    repeat (20) @(posedge clk_in);
    chk({29'h0, pf, lf, dp}, {29'h0, e[2:0]});
    chk({29'h0, seen}, {29'h0, e[2:0]});
    bus(1'b0, OTD_ADDR_STATUS, 32'h0);
    chk(q & 32'h67, {25'h0, 2'b11, 2'b00, e[5:3]});
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence.
  // ****************************************************************
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    error_cnt++;
    results();
  end

  initial begin
    seed = 7367; error_cnt = 0; check_count = 0; arst_n_in = 1'b0; wake = 1'b0;
    tap = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 8'h00; htrans = 2'h0;
    hsize = 3'h2; hwdata = 32'h0; axis = 4'h2;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, OTD_ADDR_CTRL, 32'h0);
    chk(q, {30'h0, OTD_CTRL_RST});
    bus(1'b0, OTD_ADDR_IRQ_EN, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, OTD_ADDR_DBL_WIN, 32'h0);
    chk(q, OTD_DBL_WIN_RST);
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0);
    wake <= 1'b1;
    @(posedge clk_in);
    wt_valid();
    chk({31'h0, n >= TON && n <= TON + 8}, 32'h1);
    e = exp_or(4'h2);
    chk_or();
    for (g = 0; g < 18; g++) begin
      axis <= (g < 6) ? tbl[g] : tbl[($random(seed) & 32'h7FFF) % 6];
      @(posedge clk_in);
      e = exp_or(axis);
      chk_or();
    end
    axis <= 4'h0;
    chk_or();
    bus(1'b1, OTD_ADDR_IRQ_CLR, 32'h7);
    bus(1'b1, OTD_ADDR_IRQ_EN, 32'h3);
    tp();
    repeat (20) @(posedge clk_in);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, OTD_ADDR_IRQ_ST, 32'h0);
    chk(q & 32'h3, 32'h1);
    bus(1'b1, OTD_ADDR_IRQ_CLR, 32'h7);
    bus(1'b1, OTD_ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    tp();
    repeat (20) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OTD_ADDR_IRQ_CLR, 32'h7);
    bus(1'b1, OTD_ADDR_CTRL, 32'h0);
    tp();
    repeat (20) @(posedge clk_in);
    bus(1'b0, OTD_ADDR_IRQ_ST, 32'h0);
    chk(q & 32'h3, 32'h0);
    bus(1'b1, OTD_ADDR_CTRL, 32'h3);
    bus(1'b1, OTD_ADDR_DBL_WIN, WIN);
    for (g = 0; g < 6; g++) begin
      tp();
      repeat ((g % 2) ? 60 : 5 + ($random(seed) & 32'hF)) @(posedge clk_in);
      tp();
      repeat (WIN + 20) @(posedge clk_in);
      bus(1'b0, OTD_ADDR_IRQ_ST, 32'h0);
      chk(q & 32'h3, (g % 2) ? 32'h1 : 32'h2);
      bus(1'b1, OTD_ADDR_IRQ_CLR, 32'h7);
    end
    wake <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk({28'h0, valid, pf, lf, dp}, 32'h0);
    bus(1'b0, OTD_ADDR_STATUS, 32'h0);
    chk(q & 32'h67, 32'h0);
    tp();
    repeat (WIN + 20) @(posedge clk_in);
    bus(1'b0, OTD_ADDR_IRQ_ST, 32'h0);
    chk(q & 32'h7, 32'h0);
    wake <= 1'b1;
    axis <= 4'h5;
    @(posedge clk_in);
    wt_valid();
    e = exp_or(4'h5);
    chk_or();
    bus(1'b0, OTD_ADDR_IRQ_ST, 32'h0);
    chk(q & 32'h4, 32'h4);
    results();
  end
endmodule
`default_nettype wire
